// ---- rtl/scs_pkg.sv ----
package scs_pkg;

  // ==========================================================
  // field widths and encodings
  localparam int SEL_W = 2;
  localparam int DIV_W = 10;
  localparam logic [SEL_W-1:0] SEL_WAKEUP = 2'h0;
  localparam logic [SEL_W-1:0] SEL_RSVD = 2'h1;
  localparam logic [SEL_W-1:0] SEL_PLL = 2'h2;
  localparam logic [SEL_W-1:0] SEL_DIRECT = 2'h3;

  // ==========================================================
  // source vector bit positions, after synchronisation
  localparam int SRC_N = 5;
  localparam int SRC_DIRECT = 0;
  localparam int SRC_CRYSTAL = 1;
  localparam int SRC_INTERNAL = 2;
  localparam int SRC_WAKEUP = 3;
  localparam int SRC_PLL = 4;

  localparam logic [DIV_W-1:0] DIV_ONE = 10'h000;
  localparam logic [DIV_W-1:0] CNT_STEP = 10'h001;

  // ==========================================================
  // system_config_register_0 contents, driven by on-chip logic
  typedef struct packed {
    logic [SEL_W-1:0] clock_source_select;
    logic vco_bypass;
    logic osc_from_crystal;
    logic [DIV_W-1:0] prescaler_divider_field;
  } scs_cfg_t;

  localparam scs_cfg_t CFG_RESET = '{
    clock_source_select: SEL_WAKEUP,
    vco_bypass: 1'b0,
    osc_from_crystal: 1'b0,
    prescaler_divider_field: DIV_ONE
  };

  typedef enum logic [1:0] {
    SW_RUN = 2'b00,
    SW_PARK = 2'b01,
    SW_SETTLE = 2'b10
  } scs_sw_state_t;

endpackage

// ---- rtl/scs_sync.sv ----
`timescale 1ns/10ps
module scs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ==========================================================
  // two-flop synchroniser, one per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      logic meta_d;
      logic stable_q;
      logic stable_d;
      always_comb begin
        meta_d = async_in[i];
        stable_d = meta_q;
      end
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          meta_q <= 1'b0;
          stable_q <= 1'b0;
        end else begin
          meta_q <= meta_d;
          stable_q <= stable_d;
        end
      end
      assign sync_out[i] = stable_q;
    end
  endgenerate

endmodule

// ---- rtl/scs_clock_select.sv ----
`timescale 1ns/10ps
module scs_clock_select (
  input wire logic ref_clk,
  input wire logic rst,
  input wire scs_pkg::scs_cfg_t cfg,
  input wire logic direct_clock_input,
  input wire logic crystal_input,
  input wire logic internal_clock_input,
  input wire logic wakeup_clock_input,
  input wire logic pll_clock_input,
  output logic sys_clk_q,
  output logic pll_enable_q,
  output scs_pkg::scs_cfg_t active_cfg_q,
  output logic switching_q
);
  import scs_pkg::*;

  // ==========================================================
  // source synchronisation
  logic [SRC_N-1:0] src_raw;
  logic [SRC_N-1:0] src_s;

  assign src_raw[SRC_DIRECT] = direct_clock_input;
  assign src_raw[SRC_CRYSTAL] = crystal_input;
  assign src_raw[SRC_INTERNAL] = internal_clock_input;
  assign src_raw[SRC_WAKEUP] = wakeup_clock_input;
  assign src_raw[SRC_PLL] = pll_clock_input;

  scs_sync #(
    .WIDTH(SRC_N)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(src_raw),
    .sync_out(src_s)
  );

  // ==========================================================
  // state
  scs_sw_state_t state_q;
  scs_sw_state_t state_d;
  scs_cfg_t act_q;
  scs_cfg_t act_d;
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic osc_prev_q;
  logic osc_prev_d;
  logic sys_clk_d;
  logic pll_enable_d;
  logic switching_d;

  // ==========================================================
  // level of a source under a given configuration
  function automatic logic osc_level(input scs_cfg_t c, input logic [SRC_N-1:0] s);
    osc_level = c.osc_from_crystal ? s[SRC_CRYSTAL] : s[SRC_INTERNAL];
  endfunction

  // ceil(K/2) with K = field + 1, so the high phase is never shorter than low
  function automatic logic [DIV_W:0] high_len(input logic [DIV_W-1:0] f);
    logic [DIV_W+1:0] k;
    k = {2'b00, f} + {{(DIV_W+1){1'b0}}, 1'b1};
    high_len = k[DIV_W+1:1] + {{DIV_W{1'b0}}, k[0]};
  endfunction

  logic osc_lvl;
  logic osc_rise;
  logic div_lvl;
  logic src_lvl;
  logic new_lvl;
  logic div_mode;

  always_comb begin
    osc_lvl = osc_level(act_q, src_s);
    osc_rise = osc_lvl & ~osc_prev_q;
    div_lvl = ({1'b0, cnt_q} < high_len(act_q.prescaler_divider_field));
    div_mode = (act_q.clock_source_select == SEL_PLL) && act_q.vco_bypass
      && (act_q.prescaler_divider_field != DIV_ONE);
    new_lvl = 1'b0;
    case (cfg.clock_source_select)
      SEL_DIRECT: new_lvl = src_s[SRC_DIRECT];
      SEL_WAKEUP: new_lvl = src_s[SRC_WAKEUP];
      SEL_PLL: new_lvl = cfg.vco_bypass ? osc_level(cfg, src_s) : src_s[SRC_PLL];
      default: new_lvl = 1'b0;
    endcase
    src_lvl = 1'b0;
    case (act_q.clock_source_select)
      SEL_DIRECT: src_lvl = src_s[SRC_DIRECT];
      SEL_WAKEUP: src_lvl = src_s[SRC_WAKEUP];
      SEL_PLL: begin
        if (act_q.vco_bypass) begin
          // factor one follows the oscillator level itself
          src_lvl = (act_q.prescaler_divider_field == DIV_ONE) ? osc_lvl : div_lvl;
        end else begin
          src_lvl = src_s[SRC_PLL];
        end
      end
      // reserved code parks the clock low rather than guess a source
      default: src_lvl = 1'b0;
    endcase
  end

  // ==========================================================
  // prescaler counter, advanced on oscillator rising edges
  always_comb begin
    // previous level of the oscillator the next config selects, so that
    // changing oscillator never shows a false rising edge
    osc_prev_d = osc_level(act_d, src_s);
    cnt_d = cnt_q;
    // keeps counting while parked, else a divided high phase never ends
    if (state_q != SW_RUN && state_q != SW_PARK) begin
      cnt_d = '0;
    end else if (osc_rise) begin
      // wraps after field+1 edges, 10 bits reach a factor of 1024
      cnt_d = (cnt_q == act_q.prescaler_divider_field) ? '0 : cnt_q + CNT_STEP;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      osc_prev_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      osc_prev_q <= osc_prev_d;
    end
  end

  // ==========================================================
  // switch sequencer: finish the current high phase, hold low,
  // then release once the new source is low itself, or on an oscillator rising edge when divided
  always_comb begin
    state_d = state_q;
    act_d = act_q;
    sys_clk_d = 1'b0;
    case (state_q)
      SW_RUN: begin
        sys_clk_d = src_lvl;
        if (cfg != act_q) begin
          state_d = SW_PARK;
        end
      end
      SW_PARK: begin
        // never cut a high phase short
        sys_clk_d = sys_clk_q & src_lvl;
        if (!sys_clk_q) begin
          sys_clk_d = 1'b0;
          act_d = cfg;
          state_d = SW_SETTLE;
        end
      end
      SW_SETTLE: begin
        sys_clk_d = 1'b0;
        if (cfg != act_q) begin
          act_d = cfg;
        end else if (div_mode ? osc_rise : !new_lvl) begin
          // divided path starts on an oscillator edge, first period whole
          state_d = SW_RUN;
        end
      end
      default: begin
        state_d = SW_RUN;
        sys_clk_d = 1'b0;
      end
    endcase
    pll_enable_d = (act_d.clock_source_select == SEL_PLL) && !act_d.vco_bypass;
    switching_d = (state_d != SW_RUN);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= SW_SETTLE;
      act_q <= CFG_RESET;
      sys_clk_q <= 1'b0;
      pll_enable_q <= 1'b0;
      switching_q <= 1'b1;
    end else begin
      state_q <= state_d;
      act_q <= act_d;
      sys_clk_q <= sys_clk_d;
      pll_enable_q <= pll_enable_d;
      switching_q <= switching_d;
    end
  end

  assign active_cfg_q = act_q;

  // ==========================================================
  // checks
  logic run_now;
  assign run_now = (state_q == SW_RUN) && (cfg == act_q);

  direct_drive_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (run_now && act_q.clock_source_select == SEL_DIRECT)
    |=> sys_clk_q == $past(src_s[SRC_DIRECT]))
    else $error("direct drive does not follow the direct clock input");

  presc_path_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (run_now && act_q.clock_source_select == SEL_PLL && act_q.vco_bypass
     && act_q.prescaler_divider_field != DIV_ONE)
    |=> sys_clk_q == $past(div_lvl))
    else $error("prescaler mode output not taken from the divider");

  presc_wrap_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state_q == SW_RUN && osc_rise && cnt_q == act_q.prescaler_divider_field)
    |=> cnt_q == '0)
    else $error("prescaler count did not wrap at divider field");

  presc_step_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state_q == SW_RUN && osc_rise && cnt_q != act_q.prescaler_divider_field)
    |=> cnt_q == $past(cnt_q) + CNT_STEP)
    else $error("prescaler count did not advance on oscillator edge");

  presc_unity_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (run_now && act_q.clock_source_select == SEL_PLL && act_q.vco_bypass
     && act_q.prescaler_divider_field == DIV_ONE)
    |=> sys_clk_q == $past(osc_lvl))
    else $error("unity factor does not pass the oscillator level");

  presc_range_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    state_q == SW_RUN |-> cnt_q <= act_q.prescaler_divider_field)
    else $error("prescaler count beyond divider field");

  crystal_pass_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (run_now && act_q.clock_source_select == SEL_PLL && act_q.vco_bypass
     && act_q.osc_from_crystal && act_q.prescaler_divider_field == DIV_ONE)
    |=> sys_clk_q == $past(src_s[SRC_CRYSTAL]))
    else $error("crystal bypass with factor one is not a pass-through");

  pll_enable_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    pll_enable_q == (act_q.clock_source_select == SEL_PLL && !act_q.vco_bypass))
    else $error("pll enable disagrees with active selection");

  wakeup_pass_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (run_now && act_q.clock_source_select == SEL_WAKEUP)
    |=> sys_clk_q == $past(src_s[SRC_WAKEUP]))
    else $error("wakeup mode does not follow the wakeup clock");

  no_rise_switch_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    $rose(sys_clk_q) |-> $past(state_q) == SW_RUN)
    else $error("system clock rose while a switch was in progress");

  no_cut_high_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (sys_clk_q && state_q != SW_RUN && src_lvl) |=> sys_clk_q)
    else $error("high phase truncated during a switch");

  div_release_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state_q == SW_SETTLE && cfg == act_q && div_mode && !osc_rise) |=> state_q != SW_RUN)
    else $error("divided clock released away from an oscillator edge");

endmodule

// ---- sim/system_clock_source_select_tb.sv ----
`timescale 1ns/10ps
module system_clock_source_select_tb;
  import scs_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  scs_cfg_t cfg = CFG_RESET;
  logic [SRC_N-1:0] src = '0;
  logic sys_clk_q;
  logic pll_enable_q;
  logic switching_q;
  scs_cfg_t active_cfg_q;
  int err_count = 0;
  int num_checks = 0;
  int epoch = 0;
  // each source gets its own shape so a wrong pick shows in the period or, internal against pll, in the high time
  int hi_len [SRC_N] = '{2, 2, 3, 4, 2};
  int lo_len [SRC_N] = '{3, 4, 4, 4, 5};
  int src_cnt [SRC_N] = '{default: 0};
  logic [31:0] note_q [$];
  int min_hi = 1000000;
  int seen_ep = 0;
  int per = 0;
  int hi = 0;
  bit valid = 1'b0;
  logic last = 1'b0;

  scs_clock_select DUT (
    .ref_clk(ref_clk),
    .rst(rst),
    .cfg(cfg),
    .direct_clock_input(src[SRC_DIRECT]),
    .crystal_input(src[SRC_CRYSTAL]),
    .internal_clock_input(src[SRC_INTERNAL]),
    .wakeup_clock_input(src[SRC_WAKEUP]),
    .pll_clock_input(src[SRC_PLL]),
    .sys_clk_q(sys_clk_q),
    .pll_enable_q(pll_enable_q),
    .active_cfg_q(active_cfg_q),
    .switching_q(switching_q)
  );

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  always @(negedge ref_clk) begin
    for (int i = 0; i < SRC_N; i++) begin
      src_cnt[i] = (src_cnt[i] + 1) % (hi_len[i] + lo_len[i]);
      src[i] <= (src_cnt[i] < hi_len[i]);
    end
  end

  // ==========================================================
  // monitor: measures period and high time of the system clock
  always @(posedge ref_clk) begin
    if (rst) begin
      valid = 1'b0;
      last = 1'b0;
    end else begin
      if (seen_ep != epoch) begin
        valid = 1'b0;
        seen_ep = epoch;
      end
      if (last === 1'b0 && sys_clk_q === 1'b1) begin
        if (valid && note_q.size() > 0) begin
          check({per[15:0], hi[15:0]}, note_q.pop_front());
        end
        valid = 1'b1;
        per = 0;
        hi = 0;
      end
      if (last === 1'b1 && sys_clk_q === 1'b0 && hi < min_hi) begin
        min_hi = hi;
      end
      per++;
      if (sys_clk_q === 1'b1) begin
        hi++;
      end
      last = sys_clk_q;
    end
  end

  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  function automatic scs_cfg_t mk(logic [1:0] s, logic b, logic x, logic [9:0] d);
    scs_cfg_t c;
    c = '{clock_source_select: s, vco_bypass: b, osc_from_crystal: x,
      prescaler_divider_field: d};
    return c;
  endfunction

  task automatic settle();
    int n;
    n = 0;
    repeat (3) @(negedge ref_clk);
    while (switching_q !== 1'b0 && n < 5000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 5000) begin
      err_count++;
      close_out();
    end
  endtask

  // apply a config, then expect n periods of the given shape
  task automatic run(input scs_cfg_t c, input int p, input int h, input int n);
    int k;
    cfg = c;
    settle();
    check(32'(active_cfg_q), 32'(c));
    check({31'h0, pll_enable_q}, {31'h0, c.clock_source_select == SEL_PLL && !c.vco_bypass});
    epoch++;
    for (k = 0; k < n; k++) note_q.push_back({p[15:0], h[15:0]});
    k = 0;
    while (note_q.size() > 0 && k < 30000) begin
      @(negedge ref_clk);
      k++;
    end
    if (k >= 30000) begin
      err_count++;
      close_out();
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin : main
    int k;
    int r;
    void'($urandom(79486));
    repeat (5) @(negedge ref_clk);
    check({31'h0, sys_clk_q}, 32'h0);
    check({31'h0, switching_q}, 32'h1);
    check(32'(active_cfg_q), 32'(CFG_RESET));
    rst = 1'b0;
    run(mk(SEL_WAKEUP, 1'b0, 1'b0, DIV_ONE), 8, 4, 3);
    run(mk(SEL_DIRECT, 1'b0, 1'b0, DIV_ONE), 5, 2, 3);
    run(mk(SEL_PLL, 1'b1, 1'b1, DIV_ONE), 6, 2, 3);
    run(mk(SEL_PLL, 1'b1, 1'b0, DIV_ONE), 7, 3, 3);
    run(mk(SEL_PLL, 1'b0, 1'b0, DIV_ONE), 7, 2, 3);
    // change again before the first switch has finished
    cfg = mk(SEL_DIRECT, 1'b0, 1'b0, DIV_ONE);
    repeat (2) @(negedge ref_clk);
    run(mk(SEL_WAKEUP, 1'b0, 1'b0, DIV_ONE), 8, 4, 2);
    for (int i = 0; i < 3; i++) begin
      r = 2 + int'($urandom % 8);
      run(mk(SEL_PLL, 1'b1, 1'b0, 10'(r - 1)), 7 * r, 7 * ((r + 1) / 2), 2);
    end
    cfg = mk(SEL_RSVD, 1'b0, 1'b0, DIV_ONE);
    repeat (100) @(negedge ref_clk);
    k = 0;
    repeat (200) begin
      @(negedge ref_clk);
      if (sys_clk_q !== 1'b0) k++;
    end
    check(k, 32'h0);
    run(mk(SEL_PLL, 1'b1, 1'b1, 10'h3FF), 6144, 3072, 1);
    // no high pulse may be shorter than the shortest source high phase
    check({31'h0, min_hi >= 2}, 32'h1);
    close_out();
  end
endmodule
